// ---- wdu_defines.vh ----
// Constants shared by the watchdog with unlock: map, encodings, reset values and rates.
`ifndef WDU_DEFINES_VH
`define WDU_DEFINES_VH

// Register space.
`define WDU_ADDR_W            12
`define WDU_ADDR_CTL_STATUS   12'hff0
`define WDU_ADDR_RELOAD_UPPER 12'hff1
`define WDU_ADDR_RELOAD_HIGH  12'hff2
`define WDU_ADDR_RELOAD_LOW   12'hff3

// Unlock keys written to the control address.
`define WDU_KEY_FIRST  8'h55
`define WDU_KEY_SECOND 8'haa

// Counter and reload.
`define WDU_COUNT_W        24
`define WDU_RELOAD_RESET   24'hffffff
`define WDU_COUNT_ZERO     24'h000000
`define WDU_COUNT_LAST     24'h000001
`define WDU_REFRESH_FLOOR  24'h000002
`define WDU_RELOAD_MIN     24'h000004

// Reset status read-back layout.
`define WDU_STAT_TIMEOUT_BIT 5
`define WDU_STAT_STOP_BIT    4
`define WDU_BYTE_ZERO        8'h00

// Byte lanes of the 24-bit count and reload word.
`define WDU_BYTE_W           8
`define WDU_UPPER_LSB        16
`define WDU_HIGH_LSB         8
`define WDU_LOW_LSB          0

// Rates: system clock and the watchdog RC oscillator it stands in for.
`define WDU_CLK_FREQ_HZ 125000000
`define WDU_RC_FREQ_HZ  10000
`define WDU_TICK_CYCLES (`WDU_CLK_FREQ_HZ / `WDU_RC_FREQ_HZ)
`define WDU_TICK_W      14

`endif

// ---- wdu_tick_div.v ----
// Divider that turns the system clock into the watchdog oscillator tick enable.
`timescale 1ns/100ps
module wdu_tick_div #(
  parameter WIDTH  = 14,
  parameter CYCLES = 12500
) (
  input  wire clk_in,
  input  wire rst_in,
  output wire tick_out
);
  localparam integer     LAST_INT = CYCLES - 1;
  localparam [WIDTH-1:0] LAST     = LAST_INT[WIDTH-1:0];
  localparam [WIDTH-1:0] ONE      = {{(WIDTH-1){1'b0}}, 1'b1};
  localparam [WIDTH-1:0] ZERO     = {WIDTH{1'b0}};

  reg [WIDTH-1:0] div_q;
  reg             tick_q;

  ////////////////////////////////////////////////////////////////////////////
  // The oscillator runs free, so the divider never restarts on enable.
  always @(posedge clk_in) begin
    if (rst_in) begin
      div_q  <= ZERO;
      tick_q <= 1'b0;
    end else if (div_q == LAST) begin
      div_q  <= ZERO;
      tick_q <= 1'b1;
    end else begin
      div_q  <= div_q + ONE;
      tick_q <= 1'b0;
    end
  end

  assign tick_out = tick_q;
endmodule

// ---- wdu_unlock_fsm.v ----
// Lock state machine guarding writes to the three reload byte registers.
`timescale 1ns/100ps
`include "wdu_defines.vh"
module wdu_unlock_fsm (
  input  wire                   clk_in,
  input  wire                   rst_in,
  input  wire                   wr_in,
  input  wire [`WDU_ADDR_W-1:0] addr_in,
  input  wire [7:0]             wdata_in,
  output wire                   upper_we_out,
  output wire                   high_we_out,
  output wire                   low_we_out
);
  localparam [4:0] ST_LOCKED  = 5'h01;
  localparam [4:0] ST_KEY1    = 5'h02;
  localparam [4:0] ST_UPPER   = 5'h04;
  localparam [4:0] ST_HIGH    = 5'h08;
  localparam [4:0] ST_LOW     = 5'h10;

  reg [4:0] state_q;
  reg [4:0] state_d;

  wire wr_ctl   = wr_in && (addr_in == `WDU_ADDR_CTL_STATUS);
  wire wr_upper = wr_in && (addr_in == `WDU_ADDR_RELOAD_UPPER);
  wire wr_high  = wr_in && (addr_in == `WDU_ADDR_RELOAD_HIGH);
  wire wr_low   = wr_in && (addr_in == `WDU_ADDR_RELOAD_LOW);

  ////////////////////////////////////////////////////////////////////////////
  // Any write that is not the next expected step drops back to locked.
  always @* begin
    state_d = state_q;
    if (wr_in) begin
      case (state_q)
        ST_LOCKED: begin
          state_d = (wr_ctl && wdata_in == `WDU_KEY_FIRST) ? ST_KEY1 : ST_LOCKED;
        end
        ST_KEY1: begin
          state_d = (wr_ctl && wdata_in == `WDU_KEY_SECOND) ? ST_UPPER : ST_LOCKED;
        end
        ST_UPPER: begin
          state_d = wr_upper ? ST_HIGH : ST_LOCKED;
        end
        ST_HIGH: begin
          state_d = wr_high ? ST_LOW : ST_LOCKED;
        end
        ST_LOW: begin
          state_d = ST_LOCKED;
        end
        default: begin
          state_d = ST_LOCKED;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register.
  always @(posedge clk_in) begin
    if (rst_in) begin
      state_q <= ST_LOCKED;
    end else begin
      state_q <= state_d;
    end
  end

  // Only the write expected in the current state reaches a reload byte.
  assign upper_we_out = wr_upper && (state_q == ST_UPPER);
  assign high_we_out  = wr_high && (state_q == ST_HIGH);
  assign low_we_out   = wr_low && (state_q == ST_LOW);
endmodule

// ---- wdu_watchdog.v ----
// Watchdog timer with reload unlock sequence, status read-back and time-out responses.
`timescale 1ns/100ps
`include "wdu_defines.vh"
module wdu_watchdog #(
  parameter TICK_CYCLES = `WDU_TICK_CYCLES,
  parameter TICK_W      = `WDU_TICK_W
) (
  input  wire                   clk_in,
  input  wire                   rst_in,
  input  wire [`WDU_ADDR_W-1:0] reg_addr_in,
  input  wire                   reg_wr_in,
  input  wire                   reg_rd_in,
  input  wire [7:0]             reg_wdata_in,
  input  wire                   refresh_in,
  input  wire                   debug_mode_in,
  input  wire                   stop_mode_in,
  input  wire                   always_on_option_in,
  input  wire                   timeout_response_option_in,
  output reg  [7:0]             reg_rdata_out,
  output reg                    irq_req_out,
  output reg                    sys_reset_out,
  output reg                    stop_recovery_out,
  output reg                    enabled_out
);

  ////////////////////////////////////////////////////////////////////////////
  // Behaviour worth knowing before integrating this block.
  //
  // The tick divider runs free from reset, so the first decrement after an
  // enable or a refresh lands anywhere within one tick period. A time-out
  // can therefore come up to one tick earlier than the nominal span.
  //
  // A reload below four is not trapped here. Software owns that limit; a
  // smaller value only shrinks the window in which a refresh still helps,
  // and a reload of two or less could never be refreshed at all.
  //
  // Once running the counter is never stopped. After any time-out it wraps
  // to all ones and keeps counting; a reset response relies on the system
  // reset to bring this block back to its reset state.
  //
  // The refresh floor applies to software refresh only. Debug mode reloads
  // every cycle whatever the count, so a halt in the debugger never leaves
  // a time-out pending.
  //
  // Status flags are sticky. A time-out in the same cycle as a status read
  // keeps its flag set: software may see a flag twice but never misses one.
  //
  // The three count reads are separate accesses. A tick between them can
  // tear the value, so software that needs it exact should read twice.
  //
  // Reads never move the lock sequencer. Any write other than the expected
  // next step, to any address, drops it back to locked, so a reload byte can
  // only change after both keys, with the bytes written upper, high, low.
  //
  // The response option and stop mode are looked at in the cycle of the
  // time-out itself; changing them later has no effect on that time-out.

  ////////////////////////////////////////////////////////////////////////////
  // Internal state.
  // Reset value of the reload word; the byte registers take their lanes of
  // it, so the three bytes and the count start from the same word.
  localparam [`WDU_COUNT_W-1:0] RELOAD_INIT = `WDU_RELOAD_RESET;

  reg [7:0]              reload_upper_byte_q;
  reg [7:0]              reload_high_byte_q;
  reg [7:0]              reload_low_byte_q;
  reg [`WDU_COUNT_W-1:0] count_q;
  reg [`WDU_COUNT_W-1:0] count_d;
  reg                    enabled_q;
  reg                    enabled_d;
  reg                    timeout_flag_q;
  reg                    stop_flag_q;
  reg                    timeout_event;
  reg [7:0]              rdata_d;

  wire                    tick;
  wire                    upper_we;
  wire                    high_we;
  wire                    low_we;
  wire [`WDU_COUNT_W-1:0] reload_value;
  wire                    status_read;
  wire                    refresh_allowed;
  wire                    resp_reset;
  wire [`WDU_COUNT_W-1:0] count_dec;
  wire                    irq_req_d;
  wire                    sys_reset_d;
  wire                    stop_recovery_d;

  // The three stored bytes form the reload word, upper byte on top.
  assign reload_value = {reload_upper_byte_q, reload_high_byte_q,
                         reload_low_byte_q};

  // A read at the shared control address is a reset status read.
  assign status_read = reg_rd_in && (reg_addr_in == `WDU_ADDR_CTL_STATUS);

  // Near the end the count can no longer be pushed back, so a late
  // refresh cannot rescue software that has already lost control.
  assign refresh_allowed = refresh_in && (count_q > `WDU_REFRESH_FLOOR);

  // High selects the reset response, low the interrupt response.
  assign resp_reset = timeout_response_option_in;

  // One step down. From zero this wraps to all ones, which is the roll-over
  // an interrupt response expects instead of a reload.
  assign count_dec = count_q - `WDU_COUNT_LAST;

  // Response decode for the registered pulses. Stop mode turns a reset
  // response into a recovery, while an interrupt response still requests
  // the interrupt so it is served once the core runs again.
  assign irq_req_d       = timeout_event && !resp_reset;
  assign sys_reset_d     = timeout_event && resp_reset && !stop_mode_in;
  assign stop_recovery_d = timeout_event && stop_mode_in;

  ////////////////////////////////////////////////////////////////////////////
  // Oscillator tick and unlock sequencer.
  wdu_tick_div #(
    .WIDTH  (TICK_W),
    .CYCLES (TICK_CYCLES)
  ) u_tick_div (
    .clk_in   (clk_in),
    .rst_in   (rst_in),
    .tick_out (tick)
  );

  wdu_unlock_fsm u_unlock_fsm (
    .clk_in       (clk_in),
    .rst_in       (rst_in),
    .wr_in        (reg_wr_in),
    .addr_in      (reg_addr_in),
    .wdata_in     (reg_wdata_in),
    .upper_we_out (upper_we),
    .high_we_out  (high_we),
    .low_we_out   (low_we)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Reload bytes change only on a write the sequencer lets through.
  // The control address itself holds no bits, so key writes store nothing.
  always @(posedge clk_in) begin
    if (rst_in) begin
      reload_upper_byte_q <= RELOAD_INIT[`WDU_UPPER_LSB +: `WDU_BYTE_W];
      reload_high_byte_q  <= RELOAD_INIT[`WDU_HIGH_LSB +: `WDU_BYTE_W];
      reload_low_byte_q   <= RELOAD_INIT[`WDU_LOW_LSB +: `WDU_BYTE_W];
    end else begin
      if (upper_we) begin
        reload_upper_byte_q <= reg_wdata_in;
      end
      if (high_we) begin
        reload_high_byte_q <= reg_wdata_in;
      end
      if (low_we) begin
        reload_low_byte_q <= reg_wdata_in;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Counter next state. Once enabled there is no path back to off.
  // Priority: first-enable load, debug refresh, software refresh, tick.
  always @* begin
    count_d       = count_q;
    enabled_d     = enabled_q;
    timeout_event = 1'b0;
    if (!enabled_q) begin
      // Idle until a refresh or the always-on option turns the timer on.
      if (refresh_in || always_on_option_in) begin
        enabled_d = 1'b1;
        count_d   = reload_value;
      end
    end else if (debug_mode_in) begin
      count_d = reload_value;
    end else if (refresh_allowed) begin
      count_d = reload_value;
    end else if (tick) begin
      // Plain decrement: from zero the count wraps to all ones and keeps
      // going, it is not reloaded.
      count_d = count_dec;
      if (count_q == `WDU_COUNT_LAST) begin
        timeout_event = 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Counter and enable registers.
  always @(posedge clk_in) begin
    if (rst_in) begin
      count_q   <= `WDU_RELOAD_RESET;
      enabled_q <= 1'b0;
    end else begin
      count_q   <= count_d;
      enabled_q <= enabled_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status flags. A time-out in the cycle of a status read still sets the
  // flag, so an event racing the clear is never lost.
  always @(posedge clk_in) begin
    if (rst_in) begin
      timeout_flag_q <= 1'b0;
      stop_flag_q    <= 1'b0;
    end else begin
      if (timeout_event) begin
        timeout_flag_q <= 1'b1;
      end else if (status_read) begin
        timeout_flag_q <= 1'b0;
      end
      if (timeout_event && stop_mode_in) begin
        stop_flag_q <= 1'b1;
      end else if (status_read) begin
        stop_flag_q <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Time-out responses, each a one-cycle registered pulse of the decode
  // above. Registering them keeps decode glitches away from the interrupt
  // controller and the reset controller.
  always @(posedge clk_in) begin
    if (rst_in) begin
      irq_req_out       <= 1'b0;
      sys_reset_out     <= 1'b0;
      stop_recovery_out <= 1'b0;
    end else begin
      irq_req_out       <= irq_req_d;
      sys_reset_out     <= sys_reset_d;
      stop_recovery_out <= stop_recovery_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data mux. Reload addresses show the live count, not the reload,
  // and the shared control address shows reset status.
  always @* begin
    rdata_d = `WDU_BYTE_ZERO;
    case (reg_addr_in)
      `WDU_ADDR_CTL_STATUS: begin
        rdata_d[`WDU_STAT_TIMEOUT_BIT] = timeout_flag_q;
        rdata_d[`WDU_STAT_STOP_BIT]    = stop_flag_q;
      end
      `WDU_ADDR_RELOAD_UPPER: begin
        rdata_d = count_q[`WDU_UPPER_LSB +: `WDU_BYTE_W];
      end
      `WDU_ADDR_RELOAD_HIGH: begin
        rdata_d = count_q[`WDU_HIGH_LSB +: `WDU_BYTE_W];
      end
      `WDU_ADDR_RELOAD_LOW: begin
        rdata_d = count_q[`WDU_LOW_LSB +: `WDU_BYTE_W];
      end
      default: begin
        rdata_d = `WDU_BYTE_ZERO;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data register, loaded one cycle after the read strobe and held
  // until the next read, so a slow master may pick it up late. Writes never
  // touch it, which keeps a status value from being lost to a key write.
  always @(posedge clk_in) begin
    if (rst_in) begin
      reg_rdata_out <= `WDU_BYTE_ZERO;
    end else if (reg_rd_in) begin
      reg_rdata_out <= rdata_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Enable state shown to the system. It is loaded from the same next value
  // as the internal enable, so the two can never disagree, not even in the
  // cycle in which the first refresh or the always-on option lands.
  always @(posedge clk_in) begin
    if (rst_in) begin
      enabled_out <= 1'b0;
    end else begin
      enabled_out <= enabled_d;
    end
  end

endmodule

// ---- wdu_watchdog_chk.sv ----
// Port-level assertions for the watchdog with unlock.
`timescale 1ns/100ps
module wdu_watchdog_chk (
  input wire        clk_in,
  input wire        rst_in,
  input wire [11:0] reg_addr_in,
  input wire        reg_rd_in,
  input wire [7:0]  reg_rdata_out,
  input wire        refresh_in,
  input wire        debug_mode_in,
  input wire        stop_mode_in,
  input wire        always_on_option_in,
  input wire        timeout_response_option_in,
  input wire        irq_req_out,
  input wire        sys_reset_out,
  input wire        stop_recovery_out,
  input wire        enabled_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);
  ////////////////////////////////////////////////////////////////////////////////
  // Time-out requests are single-cycle pulses, so a stuck request is caught here.
  irq_pulse_a: assert property (irq_req_out |=> !irq_req_out)
    else $error("interrupt request held too long");
  rst_pulse_a: assert property (sys_reset_out |=> !sys_reset_out)
    else $error("system reset request held too long");
  // The response option and stop mode steer the time-out.
  reset_mode_a: assert property (sys_reset_out |->
    $past(timeout_response_option_in) && !$past(stop_mode_in))
    else $error("system reset in wrong mode");
  irq_mode_a: assert property (irq_req_out |->
    !$past(timeout_response_option_in))
    else $error("interrupt request in reset response mode");
  stop_rec_a: assert property (stop_recovery_out |->
    $past(stop_mode_in) && $past(enabled_out))
    else $error("stop recovery outside stop mode");
  // Once running the timer can never be turned off.
  stay_on_a: assert property (enabled_out |=> enabled_out)
    else $error("timer disabled after enable");
  idle_a: assert property (!enabled_out && !refresh_in && !always_on_option_in
    |=> !enabled_out)
    else $error("timer started without a cause");
  // The edge that releases reset still sees reset, so it cannot enable yet.
  aon_start_a: assert property (!rst_in && always_on_option_in |=> enabled_out)
    else $error("always-on did not start the timer");
  // Two cycles of margin cover a time-out already in flight when debug began.
  dbg_quiet_a: assert property (debug_mode_in && $past(debug_mode_in) &&
    $past(debug_mode_in, 2) |-> !(irq_req_out || sys_reset_out || stop_recovery_out))
    else $error("time-out while in debug mode");
  unmapped_a: assert property (reg_rd_in && reg_addr_in < 12'hff0
    |=> reg_rdata_out == 8'h00)
    else $error("unmapped read not zero");
  cov_irq: cover property (irq_req_out);
  cov_rst: cover property (sys_reset_out);
  cov_stop: cover property (stop_recovery_out && irq_req_out);
endmodule

// ---- wdu_watchdog_tb.sv ----
// Self-checking bench for the watchdog with unlock, with a reference model.
`timescale 1ns/100ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin miscompares++; \
  $display("[ERR] %0t got %h exp %h", $time, (g), (e)); end end
module wdu_watchdog_tb;
  localparam int TK = 4;
  reg         clk_in = 1'b0;
  reg         rst_in = 1'b1;
  reg  [11:0] reg_addr_in = 12'h000;
  reg         reg_wr_in = 1'b0;
  reg         reg_rd_in = 1'b0;
  reg  [7:0]  reg_wdata_in = 8'h00;
  reg         refresh_in = 1'b0;
  reg         debug_mode_in = 1'b0;
  reg         stop_mode_in = 1'b0;
  reg         always_on_option_in = 1'b0;
  reg         timeout_response_option_in = 1'b0;
  wire [7:0]  reg_rdata_out;
  wire        irq_req_out;
  wire        sys_reset_out;
  wire        stop_recovery_out;
  wire        enabled_out;
  int         miscompares = 0;
  int         n_compared = 0;
  reg  [23:0] rl;
  int         st;
  reg  [23:0] c;
  reg  [7:0]  d;
  int         e;
  int         ph;
  int         seen;
  int         fire;
  // A short tick keeps every time-out within a few hundred cycles.
  wdu_watchdog #(.TICK_CYCLES(TK)) uut (
    .clk_in, .rst_in, .reg_addr_in, .reg_wr_in, .reg_rd_in, .reg_wdata_in, .refresh_in,
    .debug_mode_in, .stop_mode_in, .always_on_option_in, .timeout_response_option_in,
    .reg_rdata_out, .irq_req_out, .sys_reset_out, .stop_recovery_out, .enabled_out);
  always #4 clk_in = ~clk_in;
  ////////////////////////////////////////////////////////////////////////////////
  // One write pulse; the model tracks the lock state and the stored reload value.
  task automatic wr_reg(input [11:0] a, input [7:0] v);
    begin
      @(posedge clk_in);
      reg_addr_in <= a;
      reg_wdata_in <= v;
      reg_wr_in <= 1'b1;
      @(posedge clk_in);
      reg_wr_in <= 1'b0;
      if (st == 0 && a == 12'hff0 && v == 8'h55) st = 1;
      else if (st == 1 && a == 12'hff0 && v == 8'haa) st = 2;
      else if (st >= 2 && a == 12'hff0 + st - 1) begin
        rl[8 * (4 - st) +: 8] = v;
        st = (st == 4) ? 0 : st + 1;
      end else st = 0;
    end
  endtask
  // One read pulse; data is registered, so it is taken a cycle later.
  task automatic rd_reg(input [11:0] a, output [7:0] v);
    begin
      @(posedge clk_in);
      reg_addr_in <= a;
      reg_rd_in <= 1'b1;
      @(posedge clk_in);
      reg_rd_in <= 1'b0;
      @(posedge clk_in);
      #1 v = reg_rdata_out;
    end
  endtask
  // The three byte reads are not atomic, so callers check the full value only while the count is held.
  task automatic rd_cnt(output [23:0] v);
    begin
      rd_reg(12'hff1, v[23:16]);
      rd_reg(12'hff2, v[15:8]);
      rd_reg(12'hff3, v[7:0]);
    end
  endtask
  task report_and_stop;
    begin
      $display("compared %0d mismatches %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0)
        $display("STATUS OK");
      else
        $display("STATUS NOT OK");
      $finish;
    end
  endtask
  // Cuts a hang short; the tests need well under a tenth of this span.
  initial begin
    #400000;
    miscompares++;
    report_and_stop;
  end
  // Main sequence: reset state, four time-out flavours, debug, always-on.
  initial begin
    rl = 24'hffffff;
    st = 0;
    seen = $urandom(53615);
    repeat (12) @(posedge clk_in);
    rst_in <= 1'b0;
    rd_reg(12'hff0, d);
    `CHK(d, 8'h00)
    rd_reg(12'h123, d);
    `CHK(d, 8'h00)
    rd_cnt(c);
    `CHK(c, 24'hffffff)
    `CHK(enabled_out, 1'b0)
    for (int k = 0; k < 4; k++) begin
      @(posedge clk_in);
      timeout_response_option_in <= k[0];
      stop_mode_in <= k[1];
      c = 24'd8 + 24'($urandom % 24);
      wr_reg(12'hff0, 8'h55);
      wr_reg(12'hff0, 8'haa);
      wr_reg(12'hff1, c[23:16]);
      wr_reg(12'hff2, c[15:8]);
      wr_reg(12'hff3, c[7:0]);
      // Keys then a skipped byte: these zeros must never reach the reload.
      wr_reg(12'hff0, 8'h55);
      wr_reg(12'hff0, 8'haa);
      wr_reg(12'hff2, 8'h00);
      wr_reg(12'hff3, 8'h00);
      // Two early refreshes, then one late enough to be ignored.
      e = 0;
      ph = 0;
      while ((irq_req_out | sys_reset_out | stop_recovery_out) !== 1'b1 && e < 9000) begin
        fire = (ph < 2 && e == 3 * TK) || (ph == 2 && e == (rl - 2) * TK + 1);
        @(posedge clk_in);
        refresh_in <= fire[0];
        #1;
        e = (fire && ph < 2) ? -1 : e + 1;
        ph = (fire && ph < 2) ? ph + 1 : ph;
      end
      `CHK(e >= (rl - 1) * TK + 1 && e <= rl * TK + 2, 1'b1)
      `CHK({irq_req_out, sys_reset_out, stop_recovery_out}, {~k[0], k[0]&~k[1], k[1]})
      `CHK(enabled_out, 1'b1)
      rd_reg(12'hff0, d);
      `CHK(d, k[1] ? 8'h30 : 8'h20)
      rd_reg(12'hff0, d);
      `CHK(d, 8'h00)
      rd_cnt(c);
      `CHK(c[23:16], 8'hff)
    end
    // A refresh loads the short reload, so only debug mode can hold off the
    // time-out that would otherwise fall well inside the watch span.
    @(posedge clk_in);
    debug_mode_in <= 1'b1;
    refresh_in <= 1'b1;
    @(posedge clk_in);
    refresh_in <= 1'b0;
    seen = 0;
    repeat (80 * TK) begin
      @(posedge clk_in);
      #1 seen = seen | irq_req_out | sys_reset_out | stop_recovery_out;
    end
    `CHK(seen[0], 1'b0)
    rd_cnt(c);
    `CHK(c, rl)
    @(posedge clk_in);
    debug_mode_in <= 1'b0;
    always_on_option_in <= 1'b1;
    rst_in <= 1'b1;
    repeat (3) @(posedge clk_in);
    rst_in <= 1'b0;
    repeat (2) @(posedge clk_in);
    #1;
    `CHK(enabled_out, 1'b1)
    report_and_stop;
  end
endmodule
bind wdu_watchdog wdu_watchdog_chk chk (.clk_in, .rst_in, .reg_addr_in, .reg_rd_in,
  .reg_rdata_out, .refresh_in, .debug_mode_in, .stop_mode_in, .always_on_option_in,
  .timeout_response_option_in, .irq_req_out, .sys_reset_out, .stop_recovery_out, .enabled_out);
